// ---- rdc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rdc_top
  import rdc_pkg::*;
(
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial programming pins
  input wire logic shift_clk_i,
  input wire logic shift_data_i,
  input wire logic latch_strobe_i,
  // reference input to be divided
  input wire logic ref_in_i,
  // latched configuration
  output logic [14:0] ref_divide_value_o,
  output logic detector_polarity_o,
  output logic [3:0] pump_current_word_o,
  output logic [10:0] pump_current_ua_o,
  output logic supply_doubler_on_o,
  output logic cal_fast_o,
  // divided reference
  output logic ref_compare_o
);
  ////////////////////////////////////////////////////////////
  // link domain: serial shift register
  logic [23:0] shift_q; // serial word, msb arrives first

  // no reset here: the word is pure data and the link clock may idle
  always_ff @(posedge shift_clk_i) begin
    shift_q <= {shift_q[22:0], shift_data_i};
  end

  ////////////////////////////////////////////////////////////
  // strobe synchroniser and edge detect
  logic strobe_s1_q; // first stage, read only by second
  logic strobe_s2_q; // synchronised level
  logic strobe_s3_q; // delayed for edge detect
  logic strobe_rise; // one cycle at strobe rise
  logic addr_hit; // word addresses this register

  // two flops before use, third for the edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
      strobe_s3_q <= 1'b0;
    end else begin
      strobe_s1_q <= latch_strobe_i;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
    end
  end

  assign strobe_rise = strobe_s2_q & ~strobe_s3_q;
  assign addr_hit = (shift_q[RDC_ADDR_W-1:0] == RDC_ADDR_REF);

  ////////////////////////////////////////////////////////////
  // configuration latch
  // the shift word is read across domains only at strobe rise;
  // the host holds the shift clock still while the strobe is
  // high, so the word is stable for the whole sync delay
  logic [21:0] cfg_q; // latched data field

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_q <= RDC_CFG_RST;
    end else if (strobe_rise && addr_hit) begin
      cfg_q <= shift_q[RDC_WORD_W-1:RDC_ADDR_W];
    end
  end

  // field split of the latched word
  assign ref_divide_value_o = cfg_q[RDC_DIV_LSB +: RDC_DIV_W];
  assign detector_polarity_o = cfg_q[RDC_POL_BIT];
  assign pump_current_word_o = cfg_q[RDC_PUMP_LSB +: RDC_PUMP_W];
  assign supply_doubler_on_o = cfg_q[RDC_DBL_BIT];
  assign cal_fast_o = cfg_q[RDC_CAL_BIT];

  ////////////////////////////////////////////////////////////
  // typical pump current, registered to keep the output clean
  logic [10:0] pump_ua_q; // current in ua

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pump_ua_q <= rdc_pump_ua(RDC_CFG_RST[RDC_PUMP_LSB +: RDC_PUMP_W]);
    end else begin
      pump_ua_q <= rdc_pump_ua(cfg_q[RDC_PUMP_LSB +: RDC_PUMP_W]);
    end
  end

  assign pump_current_ua_o = pump_ua_q;

  ////////////////////////////////////////////////////////////
  // reference input synchroniser
  logic ref_s1_q; // first stage, read only by second
  logic ref_s2_q; // synchronised level
  logic ref_s3_q; // delayed for edge detect
  logic ref_edge; // rising edge of the reference

  // reference must be below half of clk_i to be counted
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_in_i;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  assign ref_edge = ref_s2_q & ~ref_s3_q;

  ////////////////////////////////////////////////////////////
  // reference divider
  logic [14:0] cnt_q; // edges seen in this period
  logic [14:0] div_q; // ratio in use this period
  logic [14:0] cnt_inc; // count including this edge
  logic term; // terminal edge of the period
  logic compare_q; // one-cycle comparison pulse

  assign cnt_inc = cnt_q + 15'h0001;
  // ratios below one count every edge; host keeps them legal
  assign term = ref_edge && (cnt_inc >= div_q);

  // period counter; new ratio taken only at terminal count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 15'h0000;
      div_q <= RDC_DIV_RST;
    end else if (term) begin
      cnt_q <= 15'h0000;
      div_q <= cfg_q[RDC_DIV_LSB +: RDC_DIV_W];
    end else if (ref_edge) begin
      cnt_q <= cnt_inc;
    end
  end

  // pulse one cycle after the terminal edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      compare_q <= 1'b0;
    end else begin
      compare_q <= term;
    end
  end

  assign ref_compare_o = compare_q;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [14:0] chk_edges_q; // edges counted by the checker

  // independent edge count since the last pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || compare_q) begin
      chk_edges_q <= 15'h0000;
    end else if (ref_edge) begin
      chk_edges_q <= chk_edges_q + 15'h0001;
    end
  end

  latch_ref_word_a: assert property (
    strobe_rise && addr_hit |=> cfg_q == $past(shift_q[23:2]))
    else $error("reference word not latched");

  ignore_other_a: assert property (
    strobe_rise && !addr_hit |=> $stable(cfg_q))
    else $error("other address changed the latch");

  hold_no_strobe_a: assert property (
    !strobe_rise |=> $stable(cfg_q))
    else $error("latch changed without strobe");

  divide_field_a: assert property (
    strobe_rise && addr_hit |=> ref_divide_value_o == $past(shift_q[16:2])
      && detector_polarity_o == $past(shift_q[17]))
    else $error("divide or polarity field misplaced");

  doubler_bit_a: assert property (
    strobe_rise && addr_hit |=> supply_doubler_on_o == $past(shift_q[22]))
    else $error("doubler enable wrong");

  cal_speed_a: assert property (
    strobe_rise && addr_hit |=> cal_fast_o == $past(shift_q[23]))
    else $error("calibration speed wrong");

  pump_current_a: assert property (
    strobe_rise && addr_hit |=> ##1
      pump_current_ua_o == 11'(({7'h00, $past(shift_q[21:18], 2)} + 11'h001) * 11'h064))
    else $error("pump current wrong");

  divide_period_a: assert property (
    compare_q && $past(div_q) >= 15'h0003 |-> chk_edges_q == $past(div_q))
    else $error("divide period wrong");

  pulse_single_a: assert property (
    compare_q |=> !compare_q)
    else $error("comparison pulse too long");

  // a new ratio must be the latched one, taken at the terminal edge
  reload_ratio_a: assert property (
    term |=> div_q == $past(cfg_q[14:0]))
    else $error("ratio not reloaded from latch");

  // mid-period latches must not disturb the running period
  hold_ratio_a: assert property (
    !term |=> $stable(div_q))
    else $error("ratio changed outside terminal count");

  pulse_after_edge_a: assert property (
    compare_q |-> $past(ref_edge))
    else $error("comparison pulse without reference edge");

  // current figure follows the latched code one cycle later
  pump_tracks_word_a: assert property (
    pump_current_ua_o == 11'(({7'h00, $past(pump_current_word_o)} + 11'h001) * 11'h064))
    else $error("pump current does not follow code");
endmodule : rdc_top
`default_nettype wire

// ---- rdc_pkg.sv ----
`default_nettype none
package rdc_pkg;
  ////////////////////////////////////////////////////////////
  // serial word layout
  localparam int RDC_WORD_W = 24;          // bits in the shift register
  localparam int RDC_DATA_W = 22;          // data field above the address
  localparam int RDC_ADDR_W = 2;           // address field at the bottom
  localparam logic [1:0] RDC_ADDR_REF = 2'h2; // binary 10 selects this word
  ////////////////////////////////////////////////////////////
  // field positions inside the data field
  localparam int RDC_DIV_LSB = 0;          // divide value, low data bits
  localparam int RDC_DIV_W = 15;           // divide value width
  localparam int RDC_POL_BIT = 15;         // detector polarity
  localparam int RDC_PUMP_LSB = 16;        // pump weights one..eight
  localparam int RDC_PUMP_W = 4;           // pump code width
  localparam int RDC_DBL_BIT = 20;         // supply doubler enable
  localparam int RDC_CAL_BIT = 21;         // calibration speed, 1 fast
  ////////////////////////////////////////////////////////////
  // reset values and current scale
  localparam logic [21:0] RDC_CFG_RST = 22'h000000; // cleared at reset
  localparam logic [14:0] RDC_DIV_RST = 15'h0003;   // smallest legal ratio
  localparam logic [10:0] RDC_PUMP_STEP_UA = 11'h064; // 100 ua per step
  // typical pump current in ua for a code, used by the logic; the checks compute it inline
  function automatic logic [10:0] rdc_pump_ua(input logic [3:0] code);
    logic [10:0] steps;
    steps = {7'h00, code} + 11'h001;
    return 11'(steps * RDC_PUMP_STEP_UA);
  endfunction : rdc_pump_ua
endpackage : rdc_pkg
`default_nettype wire

// ---- rdc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rdc_host_model (
  // serial programming pins
  output logic shift_clk_o,
  output logic shift_data_o,
  output logic latch_strobe_o
);
  // link starts low; clock and strobe idle low and still between frames
  initial begin
    shift_clk_o = 1'b0;
    shift_data_o = 1'b0;
    latch_strobe_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // one frame: 24 bits at a 15 ns link period, then a strobe
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      shift_data_o = word[i];
      #7.5 shift_clk_o = 1'b1;
      #7.5 shift_clk_o = 1'b0;
    end
    // released data line flips so a stale bit is never trusted
    shift_data_o = ~word[0];
    #10 latch_strobe_o = 1'b1;
    // strobe kept high well past three system cycles
    #40 latch_strobe_o = 1'b0;
    // shift clock stays still long after the strobe rise
    #20;
  endtask : send
endmodule : rdc_host_model
`default_nettype wire

// ---- rdc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rdc_top_tb;
  logic clk_i, rst_n_i, ref_in_i; // bench driven inputs
  wire logic shift_clk, shift_data, latch_strobe; // from host model
  logic [14:0] div; // latched outputs
  logic pol, dbl, cal, cmp;
  logic [3:0] pump;
  logic [10:0] ua;
  int fails, checks_done, pulses, p0;
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  rdc_host_model u_rdc_host_model (.shift_clk_o(shift_clk), .shift_data_o(shift_data),
    .latch_strobe_o(latch_strobe));
  rdc_top u_rdc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .shift_clk_i(shift_clk),
    .shift_data_i(shift_data), .latch_strobe_i(latch_strobe), .ref_in_i(ref_in_i),
    .ref_divide_value_o(div), .detector_polarity_o(pol), .pump_current_word_o(pump),
    .pump_current_ua_o(ua), .supply_doubler_on_o(dbl), .cal_fast_o(cal), .ref_compare_o(cmp));
  // count divided reference pulses at the falling edge, where the output has settled
  always @(negedge clk_i) if (cmp === 1'b1) pulses++;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // whole data field plus the current figure in ua
  task automatic check_cfg(input logic [21:0] d);
    check({10'h000, cal, dbl, pump, pol, div}, {10'h000, d});
    check({21'h000000, ua}, {21'h000000, 11'(({7'h00, d[19:16]} + 11'h001) * 11'h064)});
  endtask : check_cfg
  // frame plus settle time for the latch to land
  task automatic put(input logic [21:0] d, input logic [1:0] a);
    u_rdc_host_model.send({d, a});
    repeat (6) @(negedge clk_i);
  endtask : put
  // n reference edges, three cycles high and three low
  task automatic edges(input int n);
    repeat (n) begin
      ref_in_i = 1'b1;
      repeat (3) @(negedge clk_i);
      ref_in_i = 1'b0;
      repeat (3) @(negedge clk_i);
    end
    repeat (4) @(negedge clk_i);
  endtask : edges
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    finish_test();
  end
  initial begin
    rst_n_i = 1'b0;
    ref_in_i = 1'b0;
    fails = 0;
    checks_done = 0;
    pulses = 0;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    check_cfg(22'h000000);
    put(22'h388005, 2'h2);
    check_cfg(22'h388005);
    // other addresses leave the latched word alone
    for (int a = 0; a < 4; a++) if (a != 2) put(22'h0f1234, 2'(a));
    check_cfg(22'h388005);
    put(22'h0f0003, 2'h2);
    check_cfg(22'h0f0003);
    p0 = pulses;
    edges(9);
    check(32'(pulses - p0), 32'h3);
    put(22'h200004, 2'h2);
    check_cfg(22'h200004);
    p0 = pulses;
    edges(11);
    check(32'(pulses - p0), 32'h3);
    finish_test();
  end
endmodule : rdc_top_tb
`default_nettype wire
